/* File: cps_seq.sv */
// charger power-up sequencer with APB register slave
// assumes comparator inputs are asynchronous, bat_mv comes from
// logic on clk_sys, and the host runs on the same APB clock
//
// Operation
// - battery only: switch closed, regulator off
// - overcurrent opens switch, sets off bit
// - switch stays open until input or exit; the code also clears sw_off on a control write with that bit low
// - fixed order of power-up steps
// - regulator on after 220 ms valid input
// - 30 ms qualification window with test load
// - failed qualification retried every two seconds
// - pass sets input good, pulses interrupt
// - detection after input good, pulses interrupt
// - detection loads limit, power good, status
// - default mode tracks select pin live
// - voltage limit 3.9 to 5.4, reset 4.5
// - tracking takes larger of limit, battery+offset
// - converter starts after limit, soft start
// - low system voltage clamps current 200 mA
// - switch closed after start only if charging
// - pulse skip only when allowed, disable bit
// - boost after 30 ms enable and conditions
// - boost limit bit selects 0.5 or 1.2 A
// - boost reports source status 111
// - boost held while battery high, pfm first
// - fast digital clock only with regulator on
// - reset returns registers to defaults
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "cps_defs.svh"

module cps_seq
    import cps_pkg::*;
#(
    parameter int T_BIAS_CYC = `CPS_T_BIAS_MS * `CPS_CLK_KHZ,
    parameter int T_QUAL_CYC = `CPS_T_QUAL_MS * `CPS_CLK_KHZ,
    parameter int T_RETRY_CYC = `CPS_T_RETRY_MS * `CPS_CLK_KHZ,
    parameter int T_OTG_CYC = `CPS_T_OTG_MS * `CPS_CLK_KHZ,
    parameter int T_PFM_CYC = `CPS_T_PFM_US * `CPS_CLK_KHZ / 1000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator results, asynchronous
    input wire logic input_present,
    input wire logic above_sleep,
    input wire logic vbus_below_ov,
    input wire logic vbus_above_min,
    input wire logic bat_above_depl,
    input wire logic bat_overcurrent,
    input wire logic bat_above_otg_low,
    input wire logic vbus_in_sleep,
    input wire logic therm_in_window,
    input wire logic sys_below_2v2,
    input wire logic bat_below_minsys,
    input wire logic light_load,
    input wire logic select_pin,
    input wire logic ship_exit,
    // battery voltage in mV, same clock
    input wire logic [12:0] bat_mv,
    // power stage controls
    output logic battery_switch,
    output logic bias_regulator,
    output logic high_impedance_state,
    output logic test_load_on,
    output logic converter_en,
    output logic softstart_active,
    output logic boost_mode,
    output logic boost_current_select,
    output logic pulse_skip_allow,
    output logic dig_clk_fast,
    output logic [4:0] input_current_limit,
    output logic [12:0] input_voltage_limit,
    // host interrupt
    output logic host_irq_n
);

    cps_reg_t q;
    cps_reg_t d;
    logic in_ok;
    logic boost_ok;
    logic otg_ready;
    logic wr;
    logic mapped;
    logic [12:0] prog_mv;
    logic [12:0] trk_mv;

    ////////////////////////////////////////////////////////////////
    // input qualifiers from synchronised comparators
    assign in_ok = q.s2[`CPS_I_PRES] && q.s2[`CPS_I_SLEEPZ];
    assign boost_ok = q.otg_en && q.s2[`CPS_I_BAT_OTG];
    assign otg_ready = (q.ocnt >= 32'(T_OTG_CYC)) && q.s2[`CPS_I_BAT_OTG]
        && q.s2[`CPS_I_VBUS_SLEEP] && q.s2[`CPS_I_THERM];

    // apb decode, zero wait states
    assign wr = psel && penable && pwrite;
    assign mapped = (paddr[7:0] == `CPS_OFF_CTRL) || (paddr[7:0] == `CPS_OFF_LIMIT)
        || (paddr[7:0] == `CPS_OFF_STATUS) || (paddr[7:0] == `CPS_OFF_EFF);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = q.prdata;

    // programmed and tracking voltage limits
    assign prog_mv = `CPS_VLIM_BASE + 13'(q.vcode * `CPS_VLIM_STEP);

    always_comb begin
        unique case (q.trk)
            `CPS_TRK_200: trk_mv = bat_mv + `CPS_TRK_MV200;
            `CPS_TRK_250: trk_mv = bat_mv + `CPS_TRK_MV250;
            default: trk_mv = bat_mv + `CPS_TRK_MV300;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // next state of the whole block
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        d = q;
        d.s1 = {ship_exit, select_pin, light_load, bat_below_minsys,
            sys_below_2v2, therm_in_window, vbus_in_sleep, bat_above_otg_low,
            bat_overcurrent, bat_above_depl, vbus_above_min, vbus_below_ov,
            above_sleep, input_present};
        d.s2 = q.s1;
        d.irq_n = 1'b1;
        d.cnt = q.cnt + 32'h0000_0001;

        // software writes
        if (wr && paddr[7:0] == `CPS_OFF_CTRL) begin
            d.host_mode = pwdata[`CPS_B_HOST];
            d.det_en = pwdata[`CPS_B_DET];
            d.chg_en = pwdata[`CPS_B_CHG];
            d.ps_dis = pwdata[`CPS_B_PSDIS];
            d.otg_en = pwdata[`CPS_B_OTG];
            d.blim = pwdata[`CPS_B_BLIM];
            d.sw_off = pwdata[`CPS_B_SWOFF];
        end
        if (wr && paddr[7:0] == `CPS_OFF_LIMIT) begin
            d.ilim = pwdata[`CPS_F_ILIM];
            d.vcode = pwdata[`CPS_F_VCODE];
            d.trk = pwdata[`CPS_F_TRK];
        end

        // ship-mode exit re-enables the switch
        if (q.s2[`CPS_I_SHIP]) begin
            d.sw_off = 1'b0;
        end

        // otg enable age, saturating
        if (!q.otg_en) begin
            d.ocnt = 32'h0000_0000;
        end else if (q.ocnt < 32'(T_OTG_CYC)) begin
            d.ocnt = q.ocnt + 32'h0000_0001;
        end

        // power-up sequence
        unique case (q.st)
            ST_IDLE: begin
                if (in_ok) begin
                    d.st = ST_DELAY;
                    d.cnt = 32'h0000_0000;
                    d.sw_off = 1'b0;
                end else if (otg_ready) begin
                    d.st = ST_BPFM;
                    d.cnt = 32'h0000_0000;
                end
            end
            ST_DELAY: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (q.cnt >= 32'(T_BIAS_CYC - 1)) begin
                    d.st = ST_QUAL;
                    d.cnt = 32'h0000_0000;
                end
            end
            ST_QUAL: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (!q.s2[`CPS_I_BELOW_OV] || !q.s2[`CPS_I_ABOVE_MIN]) begin
                    d.st = ST_RETRY;
                    d.cnt = 32'h0000_0000;
                end else if (q.cnt >= 32'(T_QUAL_CYC - 1)) begin
                    d.st = ST_DETECT;
                    d.good = 1'b1;
                    d.irq_n = 1'b0;
                end
            end
            ST_RETRY: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (q.cnt >= 32'(T_RETRY_CYC - 1)) begin
                    d.st = ST_QUAL;
                    d.cnt = 32'h0000_0000;
                end
            end
            ST_DETECT: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (q.irq_n && (!q.host_mode || q.det_en)) begin
                    d.ilim = q.s2[`CPS_I_SEL] ? `CPS_ILIM_SDP : `CPS_ILIM_ADP;
                    d.src = q.s2[`CPS_I_SEL] ? `CPS_SRC_SDP : `CPS_SRC_ADP;
                    d.pgood = 1'b1;
                    d.det_en = 1'b0;
                    d.irq_n = 1'b0;
                    d.st = ST_VSET;
                end
            end
            ST_VSET: begin
                d.st = in_ok ? ST_CONV : ST_IDLE;
            end
            ST_CONV: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (!q.s2[`CPS_I_SYS_LOW]) begin
                    d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!in_ok) begin
                    d.st = ST_IDLE;
                end else if (!q.host_mode || q.det_en) begin
                    d.ilim = q.s2[`CPS_I_SEL] ? `CPS_ILIM_SDP : `CPS_ILIM_ADP;
                    d.src = q.s2[`CPS_I_SEL] ? `CPS_SRC_SDP : `CPS_SRC_ADP;
                    d.det_en = 1'b0;
                end
            end
            ST_BPFM: begin
                if (!boost_ok) begin
                    d.st = ST_IDLE;
                end else if (q.cnt >= 32'(T_PFM_CYC - 1)) begin
                    d.st = ST_BOOST;
                end
            end
            ST_BOOST: begin
                if (!boost_ok) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // flags fall with the input, boost reports its own code
        if (d.st == ST_IDLE) begin
            d.good = 1'b0;
            d.pgood = 1'b0;
            d.src = `CPS_SRC_NONE;
        end
        if (d.st == ST_BPFM || d.st == ST_BOOST) begin
            d.src = `CPS_SRC_OTG;
        end

        // overload trip, wins over any clear
        if (q.sw_on && q.s2[`CPS_I_BAT_OCP]) begin
            d.sw_off = 1'b1;
        end

        // battery switch per state
        unique case (d.st)
            ST_IDLE: d.sw_on = q.s2[`CPS_I_BAT_DPL] && !d.sw_off;
            ST_CONV, ST_RUN: d.sw_on = q.chg_en && !d.sw_off;
            default: d.sw_on = !d.sw_off;
        endcase

        // effective limits
        d.ieff = (q.s2[`CPS_I_SYS_LOW] && d.ilim > `CPS_ILIM_CLAMP)
            ? `CPS_ILIM_CLAMP : d.ilim;
        d.vlim = (q.trk != `CPS_TRK_OFF && trk_mv > prog_mv) ? trk_mv : prog_mv;

        // read data latched in the setup cycle
        unique case (paddr[7:0])
            `CPS_OFF_CTRL: begin
                rd[`CPS_B_HOST] = q.host_mode;
                rd[`CPS_B_DET] = q.det_en;
                rd[`CPS_B_CHG] = q.chg_en;
                rd[`CPS_B_PSDIS] = q.ps_dis;
                rd[`CPS_B_OTG] = q.otg_en;
                rd[`CPS_B_BLIM] = q.blim;
                rd[`CPS_B_SWOFF] = q.sw_off;
            end
            `CPS_OFF_LIMIT: begin
                rd[`CPS_F_ILIM] = q.ilim;
                rd[`CPS_F_VCODE] = q.vcode;
                rd[`CPS_F_TRK] = q.trk;
            end
            `CPS_OFF_STATUS: begin
                rd[`CPS_B_GOOD] = q.good;
                rd[`CPS_B_PGOOD] = q.pgood;
                rd[`CPS_F_SRC] = q.src;
                rd[`CPS_B_SWON] = q.sw_on;
                rd[`CPS_F_STATE] = q.st;
            end
            `CPS_OFF_EFF: begin
                rd[`CPS_F_VLIM] = q.vlim;
                rd[`CPS_F_IEFF] = q.ieff;
            end
            default: rd = 32'h0000_0000;
        endcase
        if (psel && !penable) begin
            d.prdata = rd;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register with defaults at reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.blim <= 1'b1;
            q.ilim <= `CPS_ILIM_RST;
            q.ieff <= `CPS_ILIM_RST;
            q.vcode <= `CPS_VCODE_RST;
            q.vlim <= `CPS_VLIM_RST;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // output decode from the registered state
    assign battery_switch = q.sw_on;
    assign bias_regulator = (q.st != ST_IDLE) && (q.st != ST_DELAY);
    assign high_impedance_state = (q.st == ST_IDLE) || (q.st == ST_DELAY);
    assign test_load_on = (q.st == ST_QUAL);
    assign converter_en = (q.st == ST_CONV) || (q.st == ST_RUN)
        || boost_mode;
    assign softstart_active = (q.st == ST_CONV);
    assign boost_mode = (q.st == ST_BPFM) || (q.st == ST_BOOST);
    assign boost_current_select = q.blim;
    assign pulse_skip_allow = !q.ps_dis && ((q.st == ST_BPFM)
        || (q.st == ST_RUN && q.s2[`CPS_I_LIGHT]
        && (!q.chg_en || q.s2[`CPS_I_BAT_MINSYS])));
    assign dig_clk_fast = bias_regulator;
    assign input_current_limit = q.ieff;
    assign input_voltage_limit = q.vlim;
    assign host_irq_n = q.irq_n;

    ////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_trip;
        battery_switch && q.s2[`CPS_I_BAT_OCP] |=> !battery_switch && q.sw_off;
    endproperty
    a_trip: assert property (p_trip) else $error("trip did not open switch");

    property p_bias_after_delay;
        $rose(bias_regulator) |-> ($past(q.st) == ST_DELAY
            && $past(q.cnt) >= 32'(T_BIAS_CYC - 1)) || ($past(q.st) == ST_IDLE && boost_mode);
    endproperty
    a_bias_after_delay: assert property (p_bias_after_delay)
        else $error("regulator rose outside delay");

    property p_qual_pass;
        $rose(q.good) |-> !host_irq_n && q.st == ST_DETECT
            && $past(q.cnt) >= 32'(T_QUAL_CYC - 1);
    endproperty
    a_qual_pass: assert property (p_qual_pass) else $error("good without pass");

    property p_retry;
        q.st == ST_QUAL && in_ok && !q.s2[`CPS_I_ABOVE_MIN] |=> q.st == ST_RETRY;
    endproperty
    a_retry: assert property (p_retry) else $error("failed source not retried");

    property p_sel_live;
        q.st == ST_RUN && in_ok && !q.host_mode && q.s2[`CPS_I_SEL]
            |=> q.ilim == `CPS_ILIM_SDP && q.src == `CPS_SRC_SDP;
    endproperty
    a_sel_live: assert property (p_sel_live) else $error("limit not from pin");

    property p_clamp;
        q.s2[`CPS_I_SYS_LOW] |=> input_current_limit <= `CPS_ILIM_CLAMP;
    endproperty
    a_clamp: assert property (p_clamp) else $error("current not clamped");

    property p_track;
        input_voltage_limit >= prog_mv || $changed(q.vcode) || $changed(q.trk);
    endproperty
    a_track: assert property (p_track) else $error("limit below programmed");

    property p_conv_pgood;
        (q.st == ST_CONV || q.st == ST_RUN) |-> q.pgood && q.good;
    endproperty
    a_conv_pgood: assert property (p_conv_pgood) else $error("converter before limit");

    property p_boost_src;
        boost_mode |-> q.src == `CPS_SRC_OTG;
    endproperty
    a_boost_src: assert property (p_boost_src) else $error("boost status wrong");

    property p_boost_entry;
        $rose(boost_mode) |-> $past(q.ocnt) >= 32'(T_OTG_CYC);
    endproperty
    a_boost_entry: assert property (p_boost_entry) else $error("boost too early");

    property p_pulse_skip_disable;
        q.ps_dis |-> !pulse_skip_allow;
    endproperty
    a_pulse_skip_disable: assert property (p_pulse_skip_disable) else $error("pulse skip not blocked");

    c_run: cover property (q.st == ST_CONV ##1 q.st == ST_RUN);
    c_retry: cover property (q.st == ST_RETRY ##1 q.st == ST_QUAL);
    c_boost: cover property (q.st == ST_BPFM ##1 q.st == ST_BOOST);
    c_trip: cover property ($rose(q.sw_off) && !battery_switch);

endmodule

/* File: cps_defs.svh */
// constants for the charger power-up sequencer
// assumes 200 MHz system clock and 32-bit APB data
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// clock and timing figures
`define CPS_CLK_KHZ 200000
`define CPS_T_BIAS_MS 220
`define CPS_T_QUAL_MS 30
`define CPS_T_RETRY_MS 2000
`define CPS_T_OTG_MS 30
`define CPS_T_PFM_US 100

// register byte offsets
`define CPS_OFF_CTRL 8'h00
`define CPS_OFF_LIMIT 8'h04
`define CPS_OFF_STATUS 8'h08
`define CPS_OFF_EFF 8'h0C

// control register bits
`define CPS_B_HOST 0
`define CPS_B_DET 1
`define CPS_B_CHG 2
`define CPS_B_PSDIS 3
`define CPS_B_OTG 4
`define CPS_B_BLIM 5
`define CPS_B_SWOFF 6

// limit register fields
`define CPS_F_ILIM 4:0
`define CPS_F_VCODE 11:8
`define CPS_F_TRK 13:12

// status register fields, then effective limit register fields
`define CPS_B_GOOD 0
`define CPS_B_PGOOD 1
`define CPS_F_SRC 4:2
`define CPS_B_SWON 8
`define CPS_F_STATE 25:16
`define CPS_F_VLIM 12:0
`define CPS_F_IEFF 20:16

// current limit codes, 100 mA per step
`define CPS_ILIM_SDP 5'h05
`define CPS_ILIM_ADP 5'h18
`define CPS_ILIM_CLAMP 5'h02
`define CPS_ILIM_RST 5'h05

// input voltage limit, 100 mV per code from 3.9 V
`define CPS_VCODE_RST 4'h6
`define CPS_VLIM_BASE 13'h0F3C
`define CPS_VLIM_STEP 13'h0064
`define CPS_VLIM_RST 13'h1194
`define CPS_TRK_OFF 2'h0
`define CPS_TRK_200 2'h1
`define CPS_TRK_250 2'h2
`define CPS_TRK_MV200 13'h00C8
`define CPS_TRK_MV250 13'h00FA
`define CPS_TRK_MV300 13'h012C

// source status codes
`define CPS_SRC_NONE 3'h0
`define CPS_SRC_SDP 3'h1
`define CPS_SRC_ADP 3'h2
`define CPS_SRC_OTG 3'h7

// synchronised comparator input indices
`define CPS_NIN 14
`define CPS_I_PRES 0
`define CPS_I_SLEEPZ 1
`define CPS_I_BELOW_OV 2
`define CPS_I_ABOVE_MIN 3
`define CPS_I_BAT_DPL 4
`define CPS_I_BAT_OCP 5
`define CPS_I_BAT_OTG 6
`define CPS_I_VBUS_SLEEP 7
`define CPS_I_THERM 8
`define CPS_I_SYS_LOW 9
`define CPS_I_BAT_MINSYS 10
`define CPS_I_LIGHT 11
`define CPS_I_SEL 12
`define CPS_I_SHIP 13

`endif

/* File: cps_pkg.sv */
// types for the charger power-up sequencer
// assumes cps_defs.svh sits in the include path
package cps_pkg;
`include "cps_defs.svh"

    // sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_DELAY = 10'h002,
        ST_QUAL = 10'h004,
        ST_RETRY = 10'h008,
        ST_DETECT = 10'h010,
        ST_VSET = 10'h020,
        ST_CONV = 10'h040,
        ST_RUN = 10'h080,
        ST_BPFM = 10'h100,
        ST_BOOST = 10'h200
    } cps_state_t;

    // whole state of the sequencer
    typedef struct packed {
        logic [`CPS_NIN-1:0] s1;
        logic [`CPS_NIN-1:0] s2;
        cps_state_t st;
        logic [31:0] cnt;
        logic [31:0] ocnt;
        logic host_mode;
        logic det_en;
        logic chg_en;
        logic ps_dis;
        logic otg_en;
        logic blim;
        logic sw_off;
        logic [4:0] ilim;
        logic [3:0] vcode;
        logic [1:0] trk;
        logic good;
        logic pgood;
        logic [2:0] src;
        logic sw_on;
        logic irq_n;
        logic [4:0] ieff;
        logic [12:0] vlim;
        logic [31:0] prdata;
    } cps_reg_t;

endpackage

/* File: cps_phy_model.sv */
// partner model: usb phy driving the select pin, host counting irq pulses
// assumes host_irq_n is an active low one-cycle pulse on clk_sys
`timescale 1ns/100ps

module cps_phy_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // host side
    input wire logic host_irq_n,
    output int irq_count,
    // phy side
    input wire logic port_is_sdp,
    output logic select_pin
);
    // last level of the interrupt line, idle high
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////
    // phy output follows port kind, host counts falling pulses
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            select_pin <= 1'b0;
            irq_count <= 0;
            irq_q <= 1'b1;
        end else begin
            select_pin <= port_is_sdp;
            irq_q <= host_irq_n;
            if (irq_q && !host_irq_n) begin
                irq_count <= irq_count + 1;
            end
        end
    end
endmodule

/* File: tb_charger_powerup_sequencer.sv */
// testbench for the charger power-up sequencer
// assumes cps_pkg, cps_seq and cps_phy_model compiled before it
`timescale 1ns/100ps

module tb_charger_powerup_sequencer
    import cps_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [13:0] ain = 14'h0000;
    logic [12:0] bat_mv = 13'h0000;
    logic sdp = 1'b0;
    logic err;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sel;
    logic irq_n;
    wire [9:0] mon;
    logic [4:0] ilim;
    logic [12:0] vlim;
    int irq_count;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int offs[4] = '{0, 200, 250, 300};

    ////////////////////////////////////////////////////////////////////////
    // clock, 200 mhz
    always #2.5 clk_sys = ~clk_sys;

    // ain index = comparator index of the design
    cps_seq #(.T_BIAS_CYC(20), .T_QUAL_CYC(10), .T_RETRY_CYC(30), .T_OTG_CYC(10),
        .T_PFM_CYC(5)) cps_seq_i (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_present(ain[0]),
        .above_sleep(ain[1]), .vbus_below_ov(ain[2]), .vbus_above_min(ain[3]),
        .bat_above_depl(ain[4]), .bat_overcurrent(ain[5]), .bat_above_otg_low(ain[6]),
        .vbus_in_sleep(ain[7]), .therm_in_window(ain[8]), .sys_below_2v2(ain[9]),
        .bat_below_minsys(ain[10]), .light_load(ain[11]), .select_pin(sel),
        .ship_exit(ain[13]), .bat_mv(bat_mv), .battery_switch(mon[0]),
        .bias_regulator(mon[1]), .high_impedance_state(mon[2]), .test_load_on(mon[3]),
        .converter_en(mon[4]), .softstart_active(mon[5]), .boost_mode(mon[6]),
        .boost_current_select(mon[7]), .pulse_skip_allow(mon[8]),
        .dig_clk_fast(mon[9]), .input_current_limit(ilim),
        .input_voltage_limit(vlim), .host_irq_n(irq_n));

    cps_phy_model cps_phy_model_i (.clk_sys(clk_sys), .rstn(rstn), .host_irq_n(irq_n),
        .irq_count(irq_count), .port_is_sdp(sdp), .select_pin(sel));

    ////////////////////////////////////////////////////////////////////////
    // comparison, verdict and hang guard
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask

    task finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // cycle ceiling
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb master and helpers
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rdm(input logic [31:0] a, m, e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r & m, e);
    endtask

    task automatic wait_bit(input int i, input logic v, input int n);
        int k;
        k = 0;
        while (mon[i] !== v && k < n) begin
            @(posedge clk_sys);
            k++;
        end
        chk(32'(mon[i]), 32'(v));
    endtask

    task do_reset();
        ain <= 14'h0000;
        sdp <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_defaults();
        int k;
        rdm(32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0020);
        rdm(32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_0605);
        rdm(32'h0000_000C, 32'hFFFF_FFFF, 32'h0005_1194);
        rdm(32'h0000_0008, 32'h03FF_001F, 32'h0001_0000);
        rdm(32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        chk(32'(mon[7]), 32'h0000_0001);
        wr(32'h0000_0004, 32'h0000_0F05);
        repeat (2) @(posedge clk_sys);
        chk(32'(vlim), 32'd5400);
        bat_mv <= 13'd4400;
        for (k = 0; k < 4; k++) begin
            wr(32'h0000_0004, 32'h0000_0605 | (k << 12));
            repeat (2) @(posedge clk_sys);
            chk(32'(vlim), (k == 0) ? 32'd4500 : 32'(4400 + offs[k]));
        end
        bat_mv <= 13'd4200;
        repeat (3) @(posedge clk_sys);
        chk(32'(vlim), 32'd4500);
        $display("test defaults done");
    endtask

    task t_battery();
        ain[4] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(32'(mon[1:0]), 32'h0000_0001);
        ain[5] <= 1'b1;
        wait_bit(0, 1'b0, 4);
        ain[5] <= 1'b0;
        rdm(32'h0000_0000, 32'h0000_0040, 32'h0000_0040);
        repeat (10) @(posedge clk_sys);
        chk(32'(mon[0]), 32'h0000_0000);
        ain[13] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'(mon[0]), 32'h0000_0001);
        ain <= 14'h0030;
        wait_bit(0, 1'b0, 4);
        ain <= 14'h0013;
        repeat (6) @(posedge clk_sys);
        rdm(32'h0000_0000, 32'h0000_0040, 32'h0000_0000);
        $display("test battery done");
    endtask

    task t_powerup();
        ain <= 14'h021F;
        sdp <= 1'b1;
        wr(32'h0000_0000, 32'h0000_0024);
        repeat (12) @(posedge clk_sys);
        chk(32'(mon[2]), 32'h0000_0001);
        chk(32'(mon[1]), 32'h0000_0000);
        wait_bit(2, 1'b0, 20);
        chk(32'(mon[3]), 32'h0000_0001);
        chk(32'(mon[1]), 32'h0000_0001);
        chk(32'(mon[9]), 32'h0000_0001);
        wait_bit(5, 1'b1, 30);
        chk(32'(mon[4]), 32'h0000_0001);
        chk(irq_count, 32'd2);
        rdm(32'h0000_0008, 32'h0000_001F, 32'h0000_0007);
        chk(32'(ilim), 32'h0000_0002);
        ain[9] <= 1'b0;
        wait_bit(5, 1'b0, 10);
        repeat (3) @(posedge clk_sys);
        chk(32'(ilim), 32'h0000_0005);
        chk(32'(mon[0]), 32'h0000_0001);
        wr(32'h0000_0000, 32'h0000_0020);
        repeat (3) @(posedge clk_sys);
        chk(32'(mon[0]), 32'h0000_0000);
        ain[11] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'(mon[8]), 32'h0000_0001);
        wr(32'h0000_0000, 32'h0000_0028);
        chk(32'(mon[8]), 32'h0000_0000);
        sdp <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(32'(ilim), 32'h0000_0018);
        rdm(32'h0000_0008, 32'h0000_001C, 32'h0000_0008);
        wr(32'h0000_0000, 32'h0000_0001);
        sdp <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'(ilim), 32'h0000_0018);
        wr(32'h0000_0000, 32'h0000_0003);
        repeat (4) @(posedge clk_sys);
        chk(32'(ilim), 32'h0000_0005);
        rdm(32'h0000_0000, 32'h0000_0002, 32'h0000_0000);
        $display("test powerup done");
    endtask

    task t_retry();
        ain <= 14'h0217;
        wait_bit(3, 1'b1, 40);
        wait_bit(3, 1'b0, 20);
        repeat (20) @(posedge clk_sys);
        rdm(32'h0000_0008, 32'h03FF_0001, 32'h0008_0000);
        ain[3] <= 1'b1;
        wait_bit(3, 1'b1, 20);
        $display("test retry done");
    endtask

    task t_boost();
        ain <= 14'h01D0;
        wr(32'h0000_0000, 32'h0000_0030);
        repeat (5) @(posedge clk_sys);
        chk(32'(mon[6]), 32'h0000_0000);
        wait_bit(6, 1'b1, 20);
        chk(32'(mon[8]), 32'h0000_0001);
        rdm(32'h0000_0008, 32'h0000_001C, 32'h0000_001C);
        wr(32'h0000_0000, 32'h0000_0010);
        chk(32'(mon[7]), 32'h0000_0000);
        ain[6] <= 1'b0;
        wait_bit(6, 1'b0, 8);
        $display("test boost done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        do_reset();
        t_defaults();
        do_reset();
        t_battery();
        do_reset();
        t_powerup();
        do_reset();
        t_retry();
        do_reset();
        t_boost();
        finish_test();
    end
endmodule
